/* File: tee_map.vh */
// Constants for the two-wire EEPROM slave: addressing, layouts and write timing
`ifndef TEE_MAP_VH
`define TEE_MAP_VH
`define TEE_DEV_CODE 4'ha
`define TEE_DEN_1K 3'h0
`define TEE_DEN_2K 3'h1
`define TEE_DEN_4K 3'h2
`define TEE_DEN_8K 3'h3
`define TEE_DEN_16K 3'h4
`define TEE_ABITS_1K 7
`define TEE_ABITS_2K 8
`define TEE_ABITS_4K 9
`define TEE_ABITS_8K 10
`define TEE_ABITS_16K 11
`define TEE_PAGE_SMALL 8
`define TEE_PAGE_LARGE 16
`define TEE_WRITE_TIME_US 5000
`define TEE_CLK_MHZ 20
`define TEE_WRITE_CYCLES (`TEE_WRITE_TIME_US * `TEE_CLK_MHZ)
`endif

/* File: tee_fifo.v */
// Small valid/ready FIFO holding page bytes before they reach the array
`timescale 1ns/1ns
module tee_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr;
  reg [AW-1:0] wr_ptr;
  reg [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  always @(posedge sys_clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

/* File: tee_eeprom.v */
// Two-wire serial EEPROM slave: bus decode, page buffer, timed array write
//
// Contract
// - 1K: sixteen pages of eight, 7-bit address
// - 16K: 128 pages of sixteen, 11-bit address
// - 2K/4K/8K layouts per density table
// - Page buffer 8 or 16; partial pages allowed
// - Self-timed write ends within five milliseconds
// - Sample on clock rise, change after fall
// - Data line open drain: pull low or release
// - 1K/2K compare all three straps
// - 4K compares two upper straps only
// - 8K compares uppermost strap only
// - 16K ignores all straps
// - Protect low allows normal reads and writes
// - Protect high: ack, no write, standby
// - Address byte: 1010, three bits, R/W
// - STOP after data starts timer, ignores bus
// - Page counter wraps within page, overwrites
// - No address ack during write cycle
`timescale 1ns/1ns
`include "tee_map.vh"
module tee_eeprom #(
  parameter DENSITY = `TEE_DEN_16K,
  parameter WRITE_CYCLES = `TEE_WRITE_CYCLES
) (
  input wire sys_clk,
  input wire reset_n,
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire strap_bit_zero,
  input wire strap_bit_one,
  input wire strap_bit_two,
  input wire write_protect,
  output wire write_busy
);
  localparam ABITS = (DENSITY == `TEE_DEN_1K) ? `TEE_ABITS_1K :
                     (DENSITY == `TEE_DEN_2K) ? `TEE_ABITS_2K :
                     (DENSITY == `TEE_DEN_4K) ? `TEE_ABITS_4K :
                     (DENSITY == `TEE_DEN_8K) ? `TEE_ABITS_8K : `TEE_ABITS_16K;
  localparam PAGE = (DENSITY <= `TEE_DEN_2K) ? `TEE_PAGE_SMALL : `TEE_PAGE_LARGE;
  localparam PBITS = (PAGE == 8) ? 3 : 4;
  localparam DEPTH = 1 << ABITS;
  // Bus states; S_BUSY leaves the pins unread until the write ends
  localparam S_IDLE = 3'h0;
  localparam S_DEV = 3'h1;
  localparam S_WORD = 3'h2;
  localparam S_WDATA = 3'h3;
  localparam S_RDATA = 3'h4;
  localparam S_RACK = 3'h5;
  localparam S_BUSY = 3'h6;
  // Reset enters at once but leaves in step with the clock
  reg rst_a;
  reg rst_n;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end
  // Two-stage synchronisers; only the second stage feeds logic
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg scl_d;
  reg sda_d;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 5'h03;
      sync_b <= 5'h03;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync_a <= {write_protect, strap_bit_two, strap_bit_one, sda_in, scl};
      sync_b <= sync_a;
      scl_d <= sync_b[0];
      sda_d <= sync_b[1];
    end
  end
  wire scl_s = sync_b[0];
  wire sda_s = sync_b[1];
  wire strap_s1 = sync_b[2];
  wire strap_s2 = sync_b[3];
  wire wp_s = sync_b[4];
  // Straps are hard-wired, yet still pass two flops like any pin
  reg strap_a0;
  reg strap_b0;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_a0 <= 1'b0;
      strap_b0 <= 1'b0;
    end else begin
      strap_a0 <= strap_bit_zero;
      strap_b0 <= strap_a0;
    end
  end
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c = scl_s && scl_d && !sda_d && sda_s;
  reg [7:0] array [0:DEPTH-1];
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [ABITS-1:0] addr;
  reg [2:0] page_sel;
  reg [PBITS-1:0] wr_off;
  reg [PBITS:0] loaded;
  reg wp_frame;
  reg ack_drive;
  reg [7:0] tx;
  reg [23:0] wr_timer;
  reg [PBITS:0] drained;
  // Judged on the completed byte; shift still lacks its last bit
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  // Address match per density, bits [3:1] of the address byte
  reg match;
  always @* begin
    match = (rx_byte[7:4] == `TEE_DEV_CODE);
    case (DENSITY)
      `TEE_DEN_1K, `TEE_DEN_2K:
        match = match && (rx_byte[3:1] == {strap_s2, strap_s1, strap_b0});
      `TEE_DEN_4K:
        match = match && (rx_byte[3:2] == {strap_s2, strap_s1});
      `TEE_DEN_8K:
        match = match && (rx_byte[3] == strap_s2);
      default:
        match = match;
    endcase
  end
  // Page bytes queue through the FIFO; the page buffer drains it every clock
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [PBITS+7:0] fifo_out_data;
  // Empty the queue whenever the slave is idle and not timing
  wire fifo_flush = (state == S_IDLE) && (wr_timer == 24'h000000);
  wire [ABITS-1:0] page_base = {addr[ABITS-1:PBITS], {PBITS{1'b0}}};
  wire drain = fifo_out_valid && (state == S_BUSY);
  reg [7:0] pbuf [0:PAGE-1];
  reg [PAGE-1:0] pvalid;
  wire byte_done = scl_rise && (bit_cnt == 4'h7);
  // Page-select bits sit above the word byte; the unused top is cut per density
  wire [10:0] word_full = {page_sel, rx_byte};
  // Protected frames never reach the buffer, so nothing is left to commit
  wire fifo_push = (state == S_WDATA) && byte_done && !wp_frame && fifo_in_ready;
  tee_fifo #(
    .WIDTH(PBITS+8),
    .DEPTH(4),
    .AW(2)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({wr_off, rx_byte}),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );
  // FIFO feeds the page buffer continuously; overwrite keeps the latest byte
  always @(posedge sys_clk) begin
    if (fifo_out_valid)
      pbuf[fifo_out_data[PBITS+7:8]] <= fifo_out_data[7:0];
  end
  assign write_busy = (state == S_BUSY);
  assign sda_out = 1'b0;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr <= {ABITS{1'b0}};
      page_sel <= 3'h0;
      wr_off <= {PBITS{1'b0}};
      loaded <= {(PBITS+1){1'b0}};
      wp_frame <= 1'b0;
      ack_drive <= 1'b0;
      sda_oe <= 1'b0;
      tx <= 8'h00;
      wr_timer <= 24'h000000;
      pvalid <= {PAGE{1'b0}};
      drained <= {(PBITS+1){1'b0}};
    end else if (state == S_BUSY) begin
      // Bus ignored while timing; no acks so polling sees a nack
      sda_oe <= 1'b0;
      if (wr_timer != 24'h000000)
        wr_timer <= wr_timer - 1'b1;
      else begin
        // Flags cleared so a later frame cannot replay these bytes
        state <= S_IDLE;
        pvalid <= {PAGE{1'b0}};
      end
      if (wr_timer == 24'h000002 && !fifo_out_valid) begin
        drained <= drained + 1'b1;
      end
    end else begin
      if (fifo_out_valid)
        pvalid[fifo_out_data[PBITS+7:8]] <= 1'b1;
      if (start_c) begin
        state <= S_DEV;
        bit_cnt <= 4'h0;
        ack_drive <= 1'b0;
        sda_oe <= 1'b0;
        wp_frame <= wp_s;
        // A fresh frame must not commit bytes buffered by one cut short
        pvalid <= {PAGE{1'b0}};
        loaded <= {(PBITS+1){1'b0}};
      end else if (stop_c) begin
        sda_oe <= 1'b0;
        ack_drive <= 1'b0;
        if (state == S_WDATA && loaded != {(PBITS+1){1'b0}} && !wp_frame) begin
          state <= S_BUSY;
          wr_timer <= WRITE_CYCLES[23:0] - 1'b1;
        end else begin
          // Protected or empty frames go straight back to standby
          state <= S_IDLE;
          pvalid <= {PAGE{1'b0}};
        end
        loaded <= {(PBITS+1){1'b0}};
      end else if (scl_fall) begin
        // Output changes only after the falling edge
        if (bit_cnt == 4'h8 && ack_drive) begin
          sda_oe <= 1'b1;
        end else if (state == S_RDATA && bit_cnt < 4'h8) begin
          sda_oe <= !tx[7];
          tx <= {tx[6:0], 1'b0};
        end else
          sda_oe <= 1'b0;
      end else if (scl_rise && state != S_IDLE) begin
        if (bit_cnt < 4'h8) begin
          shift <= rx_byte;
          bit_cnt <= bit_cnt + 1'b1;
          if (byte_done) begin
            ack_drive <= 1'b1;
            case (state)
              S_DEV: begin
                if (!match) begin
                  state <= S_IDLE;
                  ack_drive <= 1'b0;
                end else begin
                  page_sel <= rx_byte[3:1];
                  if (rx_byte[0]) begin
                    state <= S_RDATA;
                    tx <= array[addr];
                  end else
                    state <= S_WORD;
                end
              end
              S_WORD: begin
                addr <= word_full[ABITS-1:0];
                wr_off <= rx_byte[PBITS-1:0];
                state <= S_WDATA;
              end
              S_WDATA: begin
                wr_off <= wr_off + 1'b1;
                if (loaded != PAGE[PBITS:0])
                  loaded <= loaded + 1'b1;
              end
              S_RDATA: ack_drive <= 1'b0;
              default: ack_drive <= 1'b0;
            endcase
          end
        end else begin
          bit_cnt <= 4'h0;
          ack_drive <= 1'b0;
          // After the address byte the ninth clock carries our own ack, not the master's
          if (state == S_RDATA && !ack_drive) begin
            if (sda_s)
              state <= S_IDLE;
            else begin
              addr <= addr + 1'b1;
              tx <= array[addr + 1'b1];
            end
          end
        end
      end
    end
  end
  // Array update during the timed cycle, one buffered byte per clock
  reg [PBITS:0] commit_idx;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      commit_idx <= {(PBITS+1){1'b0}};
    else if (state != S_BUSY)
      commit_idx <= {(PBITS+1){1'b0}};
    else if (!fifo_out_valid && commit_idx != PAGE[PBITS:0])
      commit_idx <= commit_idx + 1'b1;
  end
  always @(posedge sys_clk) begin
    if (state == S_BUSY && !fifo_out_valid && commit_idx != PAGE[PBITS:0] &&
        pvalid[commit_idx[PBITS-1:0]])
      array[page_base | commit_idx[PBITS-1:0]] <= pbuf[commit_idx[PBITS-1:0]];
  end
endmodule

/* File: tee_eeprom_properties.sv */
// Pin-level checks on the EEPROM slave
`timescale 1ns/1ns
module tee_eeprom_chk #(
  parameter WRITE_CYCLES = 100000
) (
  input wire sys_clk,
  input wire reset_n,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire write_busy
);
  integer busy_cnt;
  // Counts busy cycles so the write time is bounded without long repeats
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_drain_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_after_fall: assert property ($changed(sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("data line moved near clock high");
  a_oe_hold_high: assert property (scl [*4] |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  a_busy_no_ack: assert property (write_busy |-> !sda_oe)
    else $error("data line pulled during write");
  // Write start lags the pins by the synchroniser, the detector and the state flop
  a_busy_on_stop: assert property ($rose(write_busy) |->
    $past(scl, 3) && $past(scl, 4) && $past(sda_in, 3) && !$past(sda_in, 4))
    else $error("write began without stop");
  a_busy_min_len: assert property ($rose(write_busy) |-> write_busy [*8])
    else $error("write cycle cut short");
  a_busy_bounded: assert property (busy_cnt <= WRITE_CYCLES)
    else $error("write cycle too long");
  a_busy_end_quiet: assert property ($fell(write_busy) |-> !sda_oe)
    else $error("data line pulled at write end");
endmodule
bind tee_eeprom tee_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_tee_eeprom_chk (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .scl(scl),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .write_busy(write_busy)
);

/* File: tee_master.sv */
// Behavioural two-wire bus master
`timescale 1ns/1ns
module tee_master (
  input wire sys_clk,
  input wire sda,
  output reg scl,
  output reg pull
);
  // Clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task q;
    repeat (2) @(negedge sys_clk);
  endtask
  task st;
    begin
      scl = 1'b0;
      q;
      pull = 1'b0;
      q;
      scl = 1'b1;
      q;
      pull = 1'b1;
      q;
      scl = 1'b0;
    end
  endtask
  task sp;
    begin
      q;
      pull = 1'b1;
      q;
      scl = 1'b1;
      q;
      pull = 1'b0;
      q;
    end
  endtask
  // Data moves only in the middle of clock low
  task bit_io(input b, output s);
    begin
      q;
      pull = ~b;
      q;
      scl = 1'b1;
      q;
      s = sda;
      q;
      scl = 1'b0;
    end
  endtask
  task tx(input [7:0] v, output ack);
    reg s;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(v[i], s);
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask
  task rx(input last, output [7:0] v);
    reg s;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, s);
        v[i] = s;
      end
      bit_io(last, s);
    end
  endtask
endmodule

/* File: tb.sv */
// Bench for the EEPROM slave at 4K density
`timescale 1ns/1ns
module tb;
  localparam WC = 200;
  reg sys_clk;
  reg reset_n;
  reg wp;
  reg [2:0] strap;
  reg [31:0] rs;
  reg [7:0] mem [0:511];
  reg [7:0] d;
  reg ack;
  integer err_count;
  integer samples_checked;
  integer i;
  wire scl;
  wire pull;
  wire sda_out;
  wire sda_oe;
  wire write_busy;
  wire sda = ~(pull | (sda_oe & ~sda_out));
  tee_eeprom #(.DENSITY(3'h2), .WRITE_CYCLES(WC)) i_tee_eeprom (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .scl(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .strap_bit_zero(strap[0]),
    .strap_bit_one(strap[1]),
    .strap_bit_two(strap[2]),
    .write_protect(wp),
    .write_busy(write_busy)
  );
  tee_master i_tee_master (
    .sys_clk(sys_clk),
    .sda(sda),
    .scl(scl),
    .pull(pull)
  );
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input string n, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task summarize;
    begin
      if (err_count == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task adr(input [7:0] v, input exp);
    begin
      i_tee_master.st;
      i_tee_master.tx(v, ack);
      chk("address ack", ack, exp);
    end
  endtask
  task idle;
    integer k;
    begin
      for (k = 0; k < 2 * WC && write_busy !== 1'b0; k = k + 1)
        @(negedge sys_clk);
      chk("busy end", write_busy, 1'b0);
    end
  endtask
  task wr(input [8:0] a, input integer n);
    integer k;
    begin
      adr({4'ha, 2'b10, a[8], 1'b0}, 1'b1);
      i_tee_master.tx(a[7:0], ack);
      chk("word ack", ack, 1'b1);
      for (k = 0; k < n; k = k + 1) begin
        rs = xs(rs);
        d = rs[7:0];
        i_tee_master.tx(d, ack);
        chk("data ack", ack, 1'b1);
        if (!wp)
          mem[{a[8:4], a[3:0] + k[3:0]}] = d;
      end
      i_tee_master.sp;
      for (k = 0; k < 20 && write_busy !== 1'b1; k = k + 1)
        @(negedge sys_clk);
      chk("busy start", write_busy, !wp);
      // Polling mid-write must be ignored
      if (!wp) begin
        adr({4'ha, 2'b10, a[8], 1'b0}, 1'b0);
        i_tee_master.sp;
      end
      idle;
    end
  endtask
  task rd(input [8:0] a, input integer n);
    integer k;
    begin
      adr({4'ha, 2'b10, a[8], 1'b0}, 1'b1);
      i_tee_master.tx(a[7:0], ack);
      chk("dummy word ack", ack, 1'b1);
      adr({4'ha, 2'b10, a[8], 1'b1}, 1'b1);
      for (k = 0; k < n; k = k + 1) begin
        i_tee_master.rx(k == n - 1, d);
        chk("read data", d, mem[{a[8:4], a[3:0] + k[3:0]}]);
      end
      i_tee_master.sp;
    end
  endtask
  initial begin
    reset_n = 1'b0;
    wp = 1'b0;
    strap = 3'h4;
    rs = 32'h4584;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    wr(9'h130, 18);
    rd(9'h130, 16);
    wr(9'h045, 3);
    rd(9'h045, 3);
    for (i = 0; i < 8; i = i + 1) begin
      strap = i[2:0];
      repeat (4) @(negedge sys_clk);
      adr({4'ha, 4'h8}, i[2:1] == 2'b10);
      i_tee_master.sp;
      idle;
    end
    strap = {2'b10, rs[0]};
    wp = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(9'h130, 5);
    wp = 1'b0;
    rd(9'h130, 16);
    summarize;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count = err_count + 1;
    summarize;
  end
endmodule
